// *** rtl/fhs_pkg.sv ***
// Shared constants for the floppy host status register bank
package fhs_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [3:0] IDX_DRIVE_OUTPUT_CONTROL = 4'h2;
    localparam logic [3:0] IDX_TAPE_DRIVE_ASSIGN = 4'h3;
    localparam logic [3:0] IDX_MAIN_STATUS_RATE = 4'h4;
    localparam logic [3:0] IDX_DRIVE_TYPE_CONFIG = 4'h8;
    localparam logic [3:0] IDX_BOOT_DRIVE_CONFIG = 4'h9;
    localparam logic [3:0] IDX_CONFIG_CONTROL_RATE = 4'ha;
    localparam logic [3:0] IDX_FLOPPY_MODE = 4'hb;
    localparam int ADDR_LSB = 2;

    // Reset values
    localparam logic [7:0] RST_RATE_AND_PRECOMP = 8'h02;
    localparam logic [7:0] RST_DRIVE_OUTPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_DRIVE_TYPE_CONFIG = 8'h00;
    localparam logic [7:0] RST_BOOT_DRIVE_CONFIG = 8'h00;
    localparam logic [1:0] RST_TAPE_DRIVE_ASSIGN = 2'h0;
    localparam logic [1:0] RST_CONFIG_CONTROL_RATE = 2'h2;
    localparam logic RST_FLOPPY_MODE = 1'b0;

    // Field positions
    localparam int DOR_DRIVE_SEL_LSB = 0;
    localparam int DOR_NRESET_BIT = 2;
    localparam int DSR_RATE_LSB = 0;
    localparam int DSR_PRECOMP_LSB = 2;
    localparam int DSR_LOW_POWER_BIT = 6;
    localparam int DSR_SOFT_RESET_BIT = 7;
    localparam int MODE_ENHANCED2_BIT = 0;
endpackage

// *** rtl/fhs_regs.sv ***
// Tape assignment, main status and data rate registers behind APB
//
// Functional notes
// - Tape select 00 none, else drives 1-3
// - Drive 0 never a tape drive
// - Tape assignment survives software reset
// - Normal mode: bits 7:2 undriven on read
// - Enhanced mode 2: bits 7:6 read zero
// - Enhanced: bits 5:4 selected drive type code
// - Enhanced: bits 3:2 show boot drive config
// - Main status readable anytime, no wait
// - Status bits 3:0 show drive seek activity
// - Bit 4 shows command in progress
// - Bit 5 shows polled execution phase
// - Bit 6 gives transfer direction
// - Bit 7 permits host data transfer
// - Active rate follows latest rate write
// - Hardware reset loads 02, software reset keeps
// - Bits 4:2 choose write precompensation
// - Bit 6 enters low power; wake on access
// - Bit 7 software reset, self clearing
// - Drive select bits pick one of four
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fhs_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] prdata_lane_driven,
    input wire logic [3:0] drive_seek_active,
    input wire logic cmd_busy,
    input wire logic exec_phase,
    input wire logic non_dma_selected,
    input wire logic host_transfer_request,
    input wire logic transfer_direction,
    input wire logic data_reg_access,
    output logic [3:0] tape_drive_mask,
    output logic [1:0] active_rate,
    output logic [2:0] write_precomp_select,
    output logic low_power,
    output logic soft_reset,
    output logic [3:0] drive_select_onehot
);

    ////////////////////////////////////////////////////////////////////////
    // Register map, one 8-bit register in the low byte of each word
    //
    // Word 2: drive output control, read/write, cleared by hardware reset.
    //   Bits 1:0 pick the selected drive, bit 2 low holds the controller
    //   in software reset for as long as it stays low.
    // Word 3: tape drive assignment. Bits 1:0 are the only stored bits;
    //   the upper six bits are a read image whose content depends on the
    //   floppy mode word.
    // Word 4: main status on read, rate and precompensation on write.
    //   The two share one address, so a write never changes what a read
    //   of the same word returns.
    // Word 8: per-drive type codes, two bits for each of four drives.
    // Word 9: boot drive number in bits 1:0.
    // Word 10: configuration rate, bits 1:0, read/write.
    // Word 11: floppy mode, bit 0 selects enhanced mode 2.
    //
    // Any other word, and any address with bits 1:0 set, answers with
    // pslverr and leaves every register as it was.
    //
    // Bus timing
    //
    // Every transfer has exactly one access cycle: pready is raised in the
    // cycle after setup, whatever the address. This keeps the status word
    // free of wait states, so a host polling loop costs two cycles a turn.
    // Read data is captured at the setup edge; the status word therefore
    // shows the command engine as it stood one cycle before setup. That
    // lag is harmless because the engine only changes its flags on its own
    // edges and the host re-reads status before every data byte anyway.
    //
    // Reset behaviour
    //
    // Only presetn clears the registers, apart from low power, which the software
    // reset produced here also clears. That reset goes out to the command engine and
    // leaves the rest of this bank untouched, which is what keeps the tape assignment
    // and the rate word across it.
    // soft_reset comes out of reset high, because the output-control reset
    // bit is cleared by hardware reset; software must set that bit before
    // the command engine will run.
    //
    // Low power
    //
    // Setting the low power bit only raises a level here; stopping clocks
    // is the job of whoever consumes it. A wake event in the same cycle as
    // the write that sets the bit wins, so the controller never sleeps
    // through an access that was already under way.

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Picks the two-bit type code of one drive out of the type config
    function automatic logic [1:0] type_code(input logic [7:0] cfg,
                                             input logic [1:0] drv);
        logic [1:0] code;
        code = 2'h0;
        case (drv)
            2'h0: code = cfg[1:0];
            2'h1: code = cfg[3:2];
            2'h2: code = cfg[5:4];
            default: code = cfg[7:6];
        endcase
        return code;
    endfunction

    // Binary drive number to one-hot
    function automatic logic [3:0] one_hot(input logic [1:0] drv);
        logic [3:0] oh;
        oh = 4'h0;
        oh[drv] = 1'b1;
        return oh;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] drive_output_control;
    logic [1:0] tape_drive_assign;
    logic [7:0] drive_type_config;
    logic [7:0] boot_drive_config;
    logic [1:0] config_control_rate;
    logic enhanced2;
    logic [1:0] rate_select;
    logic [2:0] precomp;
    logic [7:0] controller_main_status;
    logic sw_reset_pulse;

    logic [7:0] next_drive_output_control;
    logic [1:0] next_tape_drive_assign;
    logic [7:0] next_drive_type_config;
    logic [7:0] next_boot_drive_config;
    logic [1:0] next_config_control_rate;
    logic next_enhanced2;
    logic [1:0] next_rate_select;
    logic [2:0] next_precomp;
    logic [7:0] next_controller_main_status;
    logic next_sw_reset_pulse;
    logic next_low_power;
    logic [1:0] next_active_rate;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] next_prdata_lane_driven;

    logic setup;
    logic done;
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] tdr_read;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; pready is raised one cycle after setup

    localparam int ADDR_LSB_W = fhs_pkg::ADDR_LSB;

    assign setup = psel & ~penable;
    assign done = psel & penable & pready;
    assign wr = done & pwrite & pstrb[0];
    assign rd = done & ~pwrite;
    assign idx = paddr[ADDR_LSB_W +: 4];
    assign wbyte = pwdata[7:0];

    // Unmapped words and misaligned addresses get pslverr
    always_comb begin
        if (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0) begin
            mapped = 1'b0;
        end else if (idx == fhs_pkg::IDX_DRIVE_OUTPUT_CONTROL) begin
            mapped = 1'b1;
        end else if (idx == fhs_pkg::IDX_TAPE_DRIVE_ASSIGN) begin
            mapped = 1'b1;
        end else if (idx == fhs_pkg::IDX_MAIN_STATUS_RATE) begin
            mapped = 1'b1;
        end else if (idx == fhs_pkg::IDX_DRIVE_TYPE_CONFIG) begin
            mapped = 1'b1;
        end else if (idx == fhs_pkg::IDX_BOOT_DRIVE_CONFIG) begin
            mapped = 1'b1;
        end else if (idx == fhs_pkg::IDX_CONFIG_CONTROL_RATE) begin
            mapped = 1'b1;
        end else if (idx == fhs_pkg::IDX_FLOPPY_MODE) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Tape register read image depends on floppy mode
    always_comb begin
        if (enhanced2) begin
            tdr_read = {2'h0,
                type_code(drive_type_config,
                    drive_output_control[1:0]),
                boot_drive_config[1:0],
                tape_drive_assign};
        end else begin
            tdr_read = {6'h00, tape_drive_assign};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for registers, status and bus answer

    always_comb begin
        next_drive_output_control = drive_output_control;
        next_tape_drive_assign = tape_drive_assign;
        next_drive_type_config = drive_type_config;
        next_boot_drive_config = boot_drive_config;
        next_config_control_rate = config_control_rate;
        next_enhanced2 = enhanced2;
        next_rate_select = rate_select;
        next_precomp = precomp;
        next_active_rate = active_rate;
        next_low_power = low_power;
        next_sw_reset_pulse = 1'b0;
        next_prdata = prdata;
        next_prdata_lane_driven = prdata_lane_driven;
        next_pready = setup & ~pready;
        next_pslverr = setup & ~pready & ~mapped;

        // Status snapshot every cycle, so a read never waits
        next_controller_main_status = {
            host_transfer_request,
            transfer_direction,
            non_dma_selected & exec_phase,
            cmd_busy,
            drive_seek_active
        };

        // Read data is sampled in setup and held through access
        if (setup && !pwrite) begin
            next_prdata = 32'h0000_0000;
            next_prdata_lane_driven = 8'hff;
            if (idx == fhs_pkg::IDX_DRIVE_OUTPUT_CONTROL) begin
                next_prdata[7:0] = drive_output_control;
            end else if (idx == fhs_pkg::IDX_TAPE_DRIVE_ASSIGN) begin
                next_prdata[7:0] = tdr_read;
                if (!enhanced2) begin
                    next_prdata_lane_driven = 8'h03;
                end
            end else if (idx == fhs_pkg::IDX_MAIN_STATUS_RATE) begin
                next_prdata[7:0] = controller_main_status;
            end else if (idx == fhs_pkg::IDX_DRIVE_TYPE_CONFIG) begin
                next_prdata[7:0] = drive_type_config;
            end else if (idx == fhs_pkg::IDX_BOOT_DRIVE_CONFIG) begin
                next_prdata[7:0] = boot_drive_config;
            end else if (idx == fhs_pkg::IDX_CONFIG_CONTROL_RATE) begin
                next_prdata[1:0] = config_control_rate;
            end else if (idx == fhs_pkg::IDX_FLOPPY_MODE) begin
                next_prdata[0] = enhanced2;
            end
        end

        // Register writes take effect at the completing edge
        if (wr && mapped) begin
            if (idx == fhs_pkg::IDX_DRIVE_OUTPUT_CONTROL) begin
                next_drive_output_control = wbyte;
            end else if (idx == fhs_pkg::IDX_TAPE_DRIVE_ASSIGN) begin
                next_tape_drive_assign = wbyte[1:0];
            end else if (idx == fhs_pkg::IDX_MAIN_STATUS_RATE) begin
                // Bit 5 is not stored, so any value there is harmless
                next_rate_select = wbyte[fhs_pkg::DSR_RATE_LSB +: 2];
                next_precomp = wbyte[fhs_pkg::DSR_PRECOMP_LSB +: 3];
                next_active_rate = wbyte[fhs_pkg::DSR_RATE_LSB +: 2];
                next_low_power = wbyte[fhs_pkg::DSR_LOW_POWER_BIT];
                next_sw_reset_pulse =
                    wbyte[fhs_pkg::DSR_SOFT_RESET_BIT];
            end else if (idx == fhs_pkg::IDX_DRIVE_TYPE_CONFIG) begin
                next_drive_type_config = wbyte;
            end else if (idx == fhs_pkg::IDX_BOOT_DRIVE_CONFIG) begin
                next_boot_drive_config = wbyte;
            end else if (idx == fhs_pkg::IDX_CONFIG_CONTROL_RATE) begin
                next_config_control_rate = wbyte[1:0];
                next_active_rate = wbyte[1:0];
            end else if (idx == fhs_pkg::IDX_FLOPPY_MODE) begin
                next_enhanced2 = wbyte[fhs_pkg::MODE_ENHANCED2_BIT];
            end
        end

        // Wake on status read, data access or software reset
        if ((rd && mapped && idx == fhs_pkg::IDX_MAIN_STATUS_RATE) ||
            data_reg_access || soft_reset || sw_reset_pulse) begin
            next_low_power = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored register state and the registered bus outputs

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_output_control <= fhs_pkg::RST_DRIVE_OUTPUT_CONTROL;
            tape_drive_assign <= fhs_pkg::RST_TAPE_DRIVE_ASSIGN;
            drive_type_config <= fhs_pkg::RST_DRIVE_TYPE_CONFIG;
            boot_drive_config <= fhs_pkg::RST_BOOT_DRIVE_CONFIG;
            config_control_rate <= fhs_pkg::RST_CONFIG_CONTROL_RATE;
            enhanced2 <= fhs_pkg::RST_FLOPPY_MODE;
            rate_select <= fhs_pkg::RST_RATE_AND_PRECOMP[1:0];
            precomp <= fhs_pkg::RST_RATE_AND_PRECOMP[4:2];
            active_rate <= fhs_pkg::RST_RATE_AND_PRECOMP[1:0];
            low_power <= 1'b0;
            sw_reset_pulse <= 1'b0;
            controller_main_status <= 8'h00;
            prdata <= 32'h0000_0000;
            prdata_lane_driven <= 8'h00;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            // Software reset touches none of these registers except low_power, which it clears
            drive_output_control <= next_drive_output_control;
            tape_drive_assign <= next_tape_drive_assign;
            drive_type_config <= next_drive_type_config;
            boot_drive_config <= next_boot_drive_config;
            config_control_rate <= next_config_control_rate;
            enhanced2 <= next_enhanced2;
            rate_select <= next_rate_select;
            precomp <= next_precomp;
            active_rate <= next_active_rate;
            low_power <= next_low_power;
            sw_reset_pulse <= next_sw_reset_pulse;
            controller_main_status <= next_controller_main_status;
            prdata <= next_prdata;
            prdata_lane_driven <= next_prdata_lane_driven;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Derived outputs, also flopped so the top has no glue on its pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tape_drive_mask <= 4'h0;
            write_precomp_select <= 3'h0;
            soft_reset <= 1'b1;
            drive_select_onehot <= 4'h1;
        end else if (clk_en) begin
            // Encoding 00 leaves every mask bit clear; bit 0 never set
            tape_drive_mask <= (tape_drive_assign == 2'h0) ? 4'h0 :
                (one_hot(tape_drive_assign) & 4'he);
            write_precomp_select <= precomp;
            // Level while the output-control reset bit is low
            soft_reset <= ~next_drive_output_control[
                fhs_pkg::DOR_NRESET_BIT] | next_sw_reset_pulse;
            drive_select_onehot <= one_hot(
                next_drive_output_control[
                    fhs_pkg::DOR_DRIVE_SEL_LSB +: 2]);
        end
    end

endmodule

`default_nettype wire

// *** testbench/fhs_regs_assertions.sv ***
// Port checks for the floppy host status register bank
`timescale 1ns/1ps
`default_nettype none
module fhs_regs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] prdata_lane_driven,
    input wire logic [3:0] drive_seek_active,
    input wire logic cmd_busy,
    input wire logic exec_phase,
    input wire logic non_dma_selected,
    input wire logic host_transfer_request,
    input wire logic transfer_direction,
    input wire logic data_reg_access,
    input wire logic [3:0] tape_drive_mask,
    input wire logic [1:0] active_rate,
    input wire logic [2:0] write_precomp_select,
    input wire logic low_power,
    input wire logic soft_reset,
    input wire logic [3:0] drive_select_onehot
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////
    // Completed transfers and the expected tape mask of a write
    logic wr_ok, rd_ok;
    logic [1:0] pw_rate;
    logic [2:0] pw_pre;
    logic [3:0] mask_exp;
    assign wr_ok = pready && pwrite && !pslverr;
    assign rd_ok = pready && !pwrite && !pslverr;
    assign pw_rate = pwdata[1:0];
    assign pw_pre = pwdata[4:2];
    assign mask_exp = (pwdata[1:0] == 2'h0) ? 4'h0 : 4'h1 << pwdata[1:0];
    property p_no_wait;
        psel && !penable && clk_en |=> pready;
    endproperty
    a_no_wait: assert property (p_no_wait)
        else $error("status access waited");
    property p_status;
        rd_ok && paddr == 8'h10 |-> prdata[7:0] ==
            {$past(host_transfer_request, 2), $past(transfer_direction, 2),
             $past(exec_phase, 2) & $past(non_dma_selected, 2),
             $past(cmd_busy, 2), $past(drive_seek_active, 2)};
    endproperty
    a_status: assert property (p_status)
        else $error("status byte wrong");
    property p_lanes;
        rd_ok && prdata_lane_driven == 8'h03 |-> prdata[7:2] == 6'h00;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("undriven lanes carry data");
    property p_tape;
        wr_ok && paddr == 8'h0c |-> ##2 tape_drive_mask == $past(mask_exp, 2);
    endproperty
    a_tape: assert property (p_tape)
        else $error("tape mask wrong");
    property p_boot;
        tape_drive_mask[0] == 1'b0;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot drive marked as tape");
    property p_rate;
        wr_ok && paddr == 8'h10 |-> ##2 active_rate == $past(pw_rate, 2)
            && write_precomp_select == $past(pw_pre, 2);
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate or precomp not taken");
    property p_sleep;
        wr_ok && paddr == 8'h10 && pwdata[7:6] == 2'h1 && !data_reg_access
            |=> low_power;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("low power not entered");
    property p_wake;
        (rd_ok && paddr == 8'h10) || data_reg_access |=> !low_power;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on access");
    property p_srst;
        wr_ok && paddr == 8'h10 && pwdata[7] && !soft_reset
            |-> ##[1:2] soft_reset ##[1:3] !soft_reset;
    endproperty
    a_srst: assert property (p_srst)
        else $error("soft reset pulse wrong");
    property p_sel;
        $onehot(drive_select_onehot);
    endproperty
    a_sel: assert property (p_sel)
        else $error("drive select not one-hot");
    c_status: cover property (rd_ok && paddr == 8'h10);
    c_sleep: cover property (low_power ##1 !low_power);
    c_srst: cover property ($rose(soft_reset));
endmodule
bind fhs_regs fhs_regs_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prdata_lane_driven,
    .drive_seek_active, .cmd_busy, .exec_phase, .non_dma_selected,
    .host_transfer_request, .transfer_direction, .data_reg_access,
    .tape_drive_mask, .active_rate, .write_precomp_select, .low_power,
    .soft_reset, .drive_select_onehot);
`default_nettype wire

// *** testbench/fhs_host.sv ***
// Host processor model that issues APB transfers
`timescale 1ns/1ps
`default_nettype none
module fhs_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0
);
    // One transfer, held until pready; status polled freely
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Stale data scrambled so nothing leans on it
    endtask
endmodule
`default_nettype wire

// *** testbench/floppy_host_status_regs_bench.sv ***
// Self-checking bench for the floppy host status register bank
`timescale 1ns/1ps
`default_nettype none
module floppy_host_status_regs_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic cmd_busy, exec_phase, non_dma_selected, host_transfer_request;
    logic transfer_direction, data_reg_access, low_power, soft_reset;
    logic [3:0] drive_seek_active, tape_drive_mask, drive_select_onehot;
    logic [7:0] paddr, prdata_lane_driven;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] active_rate;
    logic [2:0] write_precomp_select;
    int err_count = 0, n_tests = 0, seed = 79, t, cr6, cr7, sel, st, rate;
    fhs_regs dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
        .prdata_lane_driven, .drive_seek_active, .cmd_busy, .exec_phase,
        .non_dma_selected, .host_transfer_request, .transfer_direction,
        .data_reg_access, .tape_drive_mask, .active_rate,
        .write_precomp_select, .low_power, .soft_reset, .drive_select_onehot);
    fhs_host host (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////
    // Shared compare, access and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
    endtask
    // Registered outputs trail the write by up to two edges
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the roughly 300 cycles the run needs
    initial begin
        #200000;
        err_count++;
        conclude;
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        data_reg_access = 1'b0;
        {host_transfer_request, transfer_direction, exec_phase} = 3'h0;
        {non_dma_selected, cmd_busy, drive_seek_active} = 6'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(active_rate, 2'h2);
        chk(write_precomp_select, 3'h0);
        for (int i = 0; i < 8; i++) begin
            {t, cr6, cr7, sel} = {$random(seed), $random(seed),
                $random(seed), i % 4};
            wr(8'h08, 32'h04 | sel);
            wr(8'h0c, t & 8'hff);
            wr(8'h20, cr6 & 8'hff);
            wr(8'h24, cr7 & 8'hff);
            wr(8'h2c, 32'h0);
            rdc(8'h0c, t & 3);
            chk(prdata_lane_driven, 8'h03);
            wr(8'h2c, 32'h1);
            rdc(8'h0c, ((cr6 >> 2 * sel) & 3) << 4 | (cr7 & 3) << 2 |
                t & 3);
            chk(tape_drive_mask, (t & 3) == 0 ? 0 : 1 << (t & 3));
            chk(drive_select_onehot, 1 << sel);
        end
        for (int i = 0; i < 6; i++) begin
            st = $random(seed);
            @(posedge pclk);
            {host_transfer_request, transfer_direction, exec_phase,
                non_dma_selected, cmd_busy, drive_seek_active} <= st[8:0];
            rdc(8'h10, {st[8:7], st[6] & st[5],
                st[4:0]});
        end
        for (int i = 0; i < 4; i++) begin
            rate = $random(seed) & 8'h1f; // Undefined bit kept zero
            wr(8'h10, rate);
            settle;
            chk(active_rate, rate & 3);
            chk(write_precomp_select, rate >> 2);
            wr(8'h28, i);
            settle;
            chk(active_rate, i);
        end
        wr(8'h10, 32'h42);
        settle;
        chk(low_power, 1'b1);
        host.xfer(1'b0, 8'h10, 32'h0, rd, er);
        settle;
        chk(low_power, 1'b0);
        wr(8'h10, 32'h42);
        data_reg_access <= 1'b1;
        @(posedge pclk);
        data_reg_access <= 1'b0;
        settle;
        chk(low_power, 1'b0);
        wr(8'h10, 32'h9d);
        wr(8'h08, 32'h00);
        settle;
        chk(soft_reset, 1'b1);
        chk(active_rate, 2'h1);
        chk(write_precomp_select, 3'h7);
        // Drive 0 is selected now, so the type code is its field
        rdc(8'h0c, (cr6 & 3) << 4 | (cr7 & 3) << 2 | t & 3);
        wr(8'h08, 32'h04);
        host.xfer(1'b0, 8'h40, 32'h0, rd, er);
        chk(er, 1'b1);
        host.xfer(1'b1, 8'h0d, 32'h0, rd, er);
        chk(er, 1'b1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(active_rate, 2'h2);
        chk(tape_drive_mask, 4'h0);
        conclude;
    end
endmodule
`default_nettype wire
